/* File: testbench/mgmt_host.sv */
// management host model on the register port
`timescale 1ns/1ns
module mgmt_host
  import phy_status_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [4:0] regAddr = 5'h00,
  output logic [15:0] regWrData = 16'h0000,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  input wire logic [15:0] regRdData
);
  // n back-to-back reads of one index, last word returned
  task automatic rd(input logic [4:0] a, input int n, output word_t d);
    regAddr <= a;
    regRead <= 1'b1;
    repeat (n) @(posedge clk);
    regRead <= 1'b0;
    // data of the last strobe stands until the next edge; take it there, before it is overwritten
    @(posedge clk);
    d = regRdData;
  endtask : rd
  task automatic wr(input logic [4:0] a, input word_t v);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    // one idle edge so a following call never reassigns the strobe in this step
    @(posedge clk);
  endtask : wr
endmodule : mgmt_host

/* File: testbench/phy_status_chk.sv */
// assertions on the phy status bank ports
`timescale 1ns/1ns
module phy_status_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  // events and interrupt
  input wire logic falseCarrier,
  input wire logic carrierValid,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // quiet read: no event in the strobe cycle, so set-wins cannot mask the clear
  sequence rdQ(a);
    regRead && regAddr == a && !falseCarrier && !carrierValid;
  endsequence
  idle_zero_a: assert property (!$past(regRead) |-> regRdData == 16'h0000)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property ($past(regRead) && $past(regAddr) == 5'h1f |-> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  fc_reserved_a: assert property (regRead && regAddr == 5'h14 |=> regRdData[15:8] == 8'h00)
    else $error("false carrier upper byte set");
  rx_reserved_a: assert property (regRead && regAddr == 5'h15 |=> regRdData[15:8] == 8'h00)
    else $error("rx error upper byte set");
  fc_clear_a: assert property (rdQ(5'h14) ##1 rdQ(5'h14) |=> regRdData == 16'h0000)
    else $error("false carrier not cleared");
  rx_clear_a: assert property (rdQ(5'h15) ##1 rdQ(5'h15) |=> regRdData == 16'h0000)
    else $error("rx error not cleared");
  fc_count_a: assert property (rdQ(5'h14) ##1 (falseCarrier && !regRead) ##1 rdQ(5'h14) |=> regRdData == 16'h0001)
    else $error("false carrier step wrong");
  fc_latch_a: assert property (falseCarrier ##1 (regRead && regAddr == 5'h10) |=> regRdData[11])
    else $error("false carrier latch missing");
  irq_clear_a: assert property (rdQ(5'h18) ##1 (!falseCarrier && !carrierValid) |=> !irq)
    else $error("irq stays after status read");
endmodule : phy_status_chk

/* File: testbench/tb_top.sv */
// bench for the phy status register bank
`timescale 1ns/1ns
module tb_top;
  import phy_status_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [5:0] live = 6'h00;
  logic falseCarrier = 1'b0, carrierValid = 1'b0, invalidSymbol = 1'b0, collision = 1'b0;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic regWrite, regRead, irq;
  int err_total = 0, samples_checked = 0, cycles = 0;
  word_t d;
  localparam logic [5:0] PATS [3] = '{6'h35, 6'h0a, 6'h3f};
  always #2 clk = ~clk;
  mgmt_host h (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData));
  phy_status_regs dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .jabberDetect(live[5]),
    .anegDone(live[4]), .loopbackOn(live[3]), .fullDuplex(live[2]), .speed10(live[1]), .linkUp(live[0]),
    .falseCarrier(falseCarrier), .carrierValid(carrierValid), .invalidSymbol(invalidSymbol),
    .collision(collision), .irq(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input word_t s, input word_t e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic fc(input int n);
    falseCarrier <= 1'b1;
    repeat (n) @(posedge clk);
    // ends on the lowering edge so a status read can follow the event at once
    falseCarrier <= 1'b0;
  endtask : fc
  // carrier event with two invalid symbols, collision all through when col
  task automatic car(input logic col);
    carrierValid <= 1'b1;
    collision <= col;
    @(posedge clk);
    invalidSymbol <= 1'b1;
    repeat (2) @(posedge clk);
    invalidSymbol <= 1'b0;
    @(posedge clk);
    carrierValid <= 1'b0;
    collision <= 1'b0;
    @(posedge clk);
  endtask : car
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    h.rd(5'h14, 1, d); chk(d, 16'h0000);
    h.rd(5'h10, 1, d); chk(d, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      live <= PATS[i];
      h.rd(5'h10, 2, d); chk(d, {10'h000, PATS[i]});
    end
    live <= 6'h00;
    h.wr(5'h14, 16'hffff);
    h.wr(5'h15, 16'hffff);
    h.rd(5'h14, 1, d); chk(d, 16'h0000);
    h.rd(5'h15, 2, d); chk(d, 16'h0000);
    fc(3);
    h.rd(5'h10, 1, d); chk(d, 16'h0800);
    h.rd(5'h14, 1, d); chk(d, 16'h0003);
    h.rd(5'h10, 1, d); chk(d, 16'h0000);
    h.rd(5'h14, 2, d);
    // one event in the idle edge between two reads of the tally
    fork
      h.rd(5'h14, 1, d);
      begin
        @(posedge clk);
        falseCarrier <= 1'b1;
        @(posedge clk);
        falseCarrier <= 1'b0;
      end
    join
    h.rd(5'h14, 1, d); chk(d, 16'h0001);
    fc(260);
    h.rd(5'h14, 1, d); chk(d, 16'h00ff);
    car(1'b0);
    h.rd(5'h10, 1, d); chk(d, 16'h2000);
    car(1'b1);
    h.rd(5'h15, 1, d); chk(d, 16'h0001);
    h.rd(5'h10, 1, d); chk(d, 16'h0000);
    repeat (300) car(1'b0);
    h.rd(5'h15, 1, d); chk(d, 16'h00ff);
    // mask only the rx error source; a false carrier must then raise irq
    h.rd(5'h18, 2, d);
    h.wr(5'h19, 16'h0001);
    h.rd(5'h19, 1, d); chk(d, 16'h0001);
    car(1'b0);
    chk({15'h0000, irq}, 16'h0000);
    fc(1);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    h.rd(5'h18, 1, d); chk(d, 16'h0003);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    fc(2);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    h.rd(5'h14, 1, d); chk(d, 16'h0000);
    h.rd(5'h1f, 1, d); chk(d, 16'h0000);
    stop_test();
  end
endmodule : tb_top
bind phy_status_regs phy_status_chk chk_i (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regRead(regRead),
  .regRdData(regRdData), .falseCarrier(falseCarrier), .carrierValid(carrierValid), .irq(irq));

/* File: verilog/phy_status_consts.svh */
// constants for the phy status and error counter register bank
`ifndef PHY_STATUS_CONSTS_SVH
`define PHY_STATUS_CONSTS_SVH
`define ADDR_W 5
`define DATA_W 16
`define OFS_STATUS 5'h10
`define OFS_FALSE_CARRIER 5'h14
`define OFS_RX_ERROR 5'h15
`define OFS_IRQ_STATUS 5'h18
`define OFS_IRQ_MASK 5'h19
`define BIT_RXERR_LATCH 13
`define BIT_FCS_LATCH 11
`define BIT_JABBER 5
`define BIT_ANEG_DONE 4
`define BIT_LOOPBACK 3
`define BIT_DUPLEX 2
`define BIT_SPEED10 1
`define BIT_LINK 0
`define TALLY_MAX 8'hff
`define IRQ_W 2
`define IRQ_FCS 0
`define IRQ_RXERR 1
`define IRQ_MASK_RESET 2'h0
`endif

/* File: verilog/phy_status_pkg.sv */
// types shared by the phy status register bank
package phy_status_pkg;
  typedef logic [7:0] tally_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    CARRIER_IDLE = 3'b001,
    CARRIER_OPEN = 3'b010,
    CARRIER_DONE = 3'b100
  } carrier_state_t;
endpackage : phy_status_pkg

/* File: verilog/phy_status_regs.sv */
// phy status word, error tallies and event interrupt register bank
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "phy_status_consts.svh"
module phy_status_regs
  import phy_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // live phy state
  input wire logic jabberDetect,
  input wire logic anegDone,
  input wire logic loopbackOn,
  input wire logic fullDuplex,
  input wire logic speed10,
  input wire logic linkUp,
  // receive path events
  input wire logic falseCarrier,
  input wire logic carrierValid,
  input wire logic invalidSymbol,
  input wire logic collision,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire selStatus = (regAddr == `OFS_STATUS);
  wire selFcs = (regAddr == `OFS_FALSE_CARRIER);
  wire selRxErr = (regAddr == `OFS_RX_ERROR);
  wire selIrqStat = (regAddr == `OFS_IRQ_STATUS);
  wire selIrqMask = (regAddr == `OFS_IRQ_MASK);
  wire rdFcs = regRead && selFcs;
  wire rdRxErr = regRead && selRxErr;
  wire rdIrqStat = regRead && selIrqStat;

  ////////////////////////////////////////////////////////////////////////////
  // receive error qualification: one count per carrier event, none with collision
  carrier_state_t carrierReg;
  carrier_state_t carrierNext;
  logic collisionSeenReg;
  wire collisionNow = collision || collisionSeenReg;
  wire rxErrEvent = carrierValid && invalidSymbol && !collisionNow && (carrierReg != CARRIER_DONE);

  always_comb begin
    carrierNext = carrierReg;
    case (carrierReg)
      CARRIER_IDLE: begin
        if (carrierValid) carrierNext = rxErrEvent ? CARRIER_DONE : CARRIER_OPEN;
      end
      CARRIER_OPEN: begin
        if (!carrierValid) carrierNext = CARRIER_IDLE;
        else if (rxErrEvent) carrierNext = CARRIER_DONE;
      end
      CARRIER_DONE: begin
        if (!carrierValid) carrierNext = CARRIER_IDLE;
      end
      default: carrierNext = CARRIER_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carrierReg <= CARRIER_IDLE;
      collisionSeenReg <= 1'b0;
    end else begin
      carrierReg <= carrierNext;
      collisionSeenReg <= carrierValid && collisionNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tallies
  tally_if fcsTl ();
  tally_if rxTl ();
  assign fcsTl.bump = falseCarrier;
  assign fcsTl.clear = rdFcs;
  assign rxTl.bump = rxErrEvent;
  assign rxTl.clear = rdRxErr;

  sat_tally fcsCounter (
    .clk(clk),
    .reset_n(reset_n),
    .tl(fcsTl)
  );
  sat_tally rxCounter (
    .clk(clk),
    .reset_n(reset_n),
    .tl(rxTl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // latched event bits; a new event beats the clearing read
  logic fcsLatch_reg;
  logic rxErrLatch_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fcsLatch_reg <= 1'b0;
      rxErrLatch_reg <= 1'b0;
    end else begin
      fcsLatch_reg <= falseCarrier || (fcsLatch_reg && !rdFcs);
      rxErrLatch_reg <= rxErrEvent || (rxErrLatch_reg && !rdRxErr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  logic [1:0] irqStat_reg;
  logic [1:0] irqMask_reg;
  logic irq_reg;
  wire [1:0] irqEvents = {rxErrEvent, falseCarrier};
  wire [1:0] irqStat_next = irqEvents | (rdIrqStat ? 2'h0 : irqStat_reg);
  // use the new mask at once so irq never lags a mask write by a cycle
  wire [1:0] irqMask_next = (regWrite && selIrqMask) ? regWrData[1:0] : irqMask_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= `IRQ_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      irq_reg <= |(irqStat_next & irqMask_next);
    end
  end
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status word: live copies plus the two latched event bits, and reading it clears nothing
  word_t statusWord;
  always_comb begin
    statusWord = 16'h0000;
    statusWord[`BIT_RXERR_LATCH] = rxErrLatch_reg;
    statusWord[`BIT_FCS_LATCH] = fcsLatch_reg;
    statusWord[`BIT_JABBER] = jabberDetect;
    statusWord[`BIT_ANEG_DONE] = anegDone;
    statusWord[`BIT_LOOPBACK] = loopbackOn;
    statusWord[`BIT_DUPLEX] = fullDuplex;
    statusWord[`BIT_SPEED10] = speed10;
    statusWord[`BIT_LINK] = linkUp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; counter upper bytes and unmapped offsets read zero, writes ignored except to the irq mask
  word_t rdMux;
  always_comb begin
    if (selStatus) rdMux = statusWord;
    else if (selFcs) rdMux = {8'h00, fcsTl.count};
    else if (selRxErr) rdMux = {8'h00, rxTl.count};
    else if (selIrqStat) rdMux = {14'h0000, irqStat_reg};
    else if (selIrqMask) rdMux = {14'h0000, irqMask_reg};
    else rdMux = 16'h0000;
  end

  word_t rdData_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rdData_reg <= 16'h0000;
    else rdData_reg <= regRead ? rdMux : 16'h0000;
  end
  assign regRdData = rdData_reg;
endmodule : phy_status_regs

/* File: verilog/sat_tally.sv */
// eight-bit saturating counter cleared on read
`timescale 1ns/1ns
`include "phy_status_consts.svh"
module sat_tally
  import phy_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // tally link
  tally_if.counter tl
);
  tally_t countReg;
  tally_t countNext;
  wire atMax = (countReg == `TALLY_MAX);

  // an event in the clearing cycle counts as one, so it is not lost
  always_comb begin
    countNext = countReg;
    if (tl.clear) begin
      countNext = tl.bump ? 8'h01 : 8'h00;
    end else if (tl.bump && !atMax) begin
      countNext = countReg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) countReg <= 8'h00;
    else countReg <= countNext;
  end

  assign tl.count = countReg;
endmodule : sat_tally

/* File: verilog/tally_if.sv */
// interface carrying one tally's count, clear and event between modules
`timescale 1ns/1ns
interface tally_if;
  logic bump;
  logic clear;
  logic [7:0] count;
  modport counter (input bump, input clear, output count);
  modport user (output bump, output clear, input count);
endinterface : tally_if
